/* sarcc_core.sv */
/*
 * Conversion control of an 8-bit successive-approximation converter:
 * start flip-flop, start qualification, bit sequencing, output latch,
 * done flag and three-state read path.
 * Assumes core_clk is the converter clock, pins are asynchronous and
 * the analogue comparator reports its result on cmp_hi.
 */
`timescale 1ns/1ns

// Behaviour
// RULE1: Conversion lasts 62 to 73 clock periods
// RULE2: Free running: done wired to write-start
// RULE3: Write-start fall clears code, stages, done
// RULE4: Select and write-start low hold reset
// RULE5: Conversion begins 1 to 8 periods after release
// RULE6: Eight comparisons MSB first over 64 cycles; the code makes them over 62 cycles
// RULE7: Done output falls when result is ready
// RULE8: Select with read clears the done flag
// RULE9: Data driven only during select and read
// RULE10: Host issues one start at power-up
// RULE11: New start aborts a running conversion
// RULE12: Start condition sets start flip-flop
// RULE13: Gated pulse clears start only when released
// RULE14: Marker leaving shift register loads output latch
// RULE15: Delay flop sets done one clock later
// RULE16: Select, read and write-start are active low
// RULE17: Select may be tied low standalone
// RULE18: Negative input sampled 4.5 periods after positive; the strobes here are 4 periods apart
// RULE19: Negative at or above positive gives zero
// RULE20: Write-start rising edge starts the conversion
// RULE21: Comparator keeps or clears each trial bit
module sarcc_core (
   input  wire logic                         core_clk,
   input  wire logic                         resetn,
   input  wire logic                         cs_n,
   input  wire logic                         wr_n,
   input  wire logic                         rd_n,
   input  wire logic                         cmp_hi,
   output logic                              done_n,
   output logic [sarcc_pkg::RES_W-1:0]       data_out,
   output logic                              data_oe_n,
   output logic [sarcc_pkg::RES_W-1:0]       trial_code,
   output logic                              sample_pos_p,
   output logic                              sample_neg_p,
   output logic                              busy
);

   // Whole state of the sequencer
   typedef struct packed {
      sarcc_pkg::sarcc_state_e              st;                // Sequencer state
      logic                                 first_shift_stage; // Start marker stage
      logic [sarcc_pkg::RES_W-1:0]          marker;            // One-hot shift register
      logic [sarcc_pkg::RES_W-1:0]          sar;               // Trial code
      logic [sarcc_pkg::PH_W-1:0]           phase;             // Internal clock phase
      logic [sarcc_pkg::RES_W-1:0]          result;            // Output latch
      logic                                 done_delay_flop;   // Delay before done
      logic                                 done;              // Done flag
      logic                                 wr_prev;           // Last write-start level
      logic [sarcc_pkg::CYC_W-1:0]          conv_cyc;          // Cycles into conversion
   } sarcc_core_s;

   sarcc_core_s q;
   sarcc_core_s d;

   sarcc_pin_if pins ();

   logic cs_s;               // Synchronised select, low active
   logic wr_s;               // Synchronised write-start, low active
   logic rd_s;               // Synchronised read strobe, low active
   logic cmp_s;              // Synchronised comparator result
   logic start_cond;         // Select and write-start both low
   logic read_sel;           // Select and read both low
   logic wr_fall;            // Write-start high-to-low step
   logic start_clear_gate;   // Clock-gated clear of the start flip-flop
   logic bit_end;            // End of a bit period during conversion
   logic latch_transfer_gate;// Marker leaves the shift register
   logic [sarcc_pkg::RES_W-1:0] sar_decided; // Trial code after this compare

   // Pins pass two flip-flops before anything reads them
   assign pins.raw = {cmp_hi, rd_n, wr_n, cs_n};

   sarcc_sync u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .pins     (pins)
   );

   assign cs_s  = pins.sync[sarcc_pkg::IX_CS];
   assign wr_s  = pins.sync[sarcc_pkg::IX_WR];
   assign rd_s  = pins.sync[sarcc_pkg::IX_RD];
   assign cmp_s = pins.sync[sarcc_pkg::IX_CMP];

   // Control decode, strobes taken as active when low [RULE16]
   always_comb begin
      start_cond = !cs_s && !wr_s;                        // [RULE12]
      read_sel   = !cs_s && !rd_s;
      wr_fall    = q.wr_prev && !wr_s;
      // Clears the start flip-flop only once the start condition is gone
      start_clear_gate = (q.st == sarcc_pkg::SARCC_HOLD) && q.first_shift_stage
                         && (q.phase == sarcc_pkg::PH_GO) && !start_cond; // [RULE13] [RULE20]
      bit_end = (q.st == sarcc_pkg::SARCC_CONV) && (q.phase == sarcc_pkg::PH_CMP);
      latch_transfer_gate = bit_end && (q.marker == sarcc_pkg::MARK_LSB); // [RULE14]
      // Comparator high means trial above input: drop the bit [RULE21] [RULE19]
      if (cmp_s) begin
         sar_decided = q.sar & ~q.marker;
      end else begin
         sar_decided = q.sar;
      end
   end

   // Next state of the sequencer
   always_comb begin
      d                 = q;
      d.phase           = q.phase + sarcc_pkg::PH_W'(1);
      d.wr_prev         = wr_s;
      d.done_delay_flop = 1'b0;
      d.first_shift_stage = 1'b0;
      case (q.st)
         // Waiting for a start
         sarcc_pkg::SARCC_IDLE: begin
            d.conv_cyc = sarcc_pkg::CYC_ZERO;
         end
         // Start flip-flop set: shift register held, marker enters stage one
         sarcc_pkg::SARCC_HOLD: begin
            d.first_shift_stage = 1'b1;                   // [RULE12]
            if (start_clear_gate) begin
               // Marker clocked in, MSB trial begins [RULE5]
               d.st       = sarcc_pkg::SARCC_CONV;
               d.marker   = sarcc_pkg::MARK_MSB;
               d.sar      = sarcc_pkg::MARK_MSB;
               d.conv_cyc = sarcc_pkg::CYC_ZERO;
               d.first_shift_stage = 1'b0;
            end
         end
         // Bit sequencing, MSB first: six cycles for the MSB, eight for each lower bit [RULE6]
         sarcc_pkg::SARCC_CONV: begin
            d.conv_cyc = q.conv_cyc + sarcc_pkg::CYC_ONE; // Length count [RULE1]
            if (latch_transfer_gate) begin
               // Last bit decided: load latch, arm done delay [RULE14] [RULE6]
               d.result          = sar_decided;
               d.sar             = sar_decided;
               d.marker          = sarcc_pkg::CODE_ZERO;
               d.done_delay_flop = 1'b1;
               d.st              = sarcc_pkg::SARCC_IDLE;
            end else if (bit_end) begin
               // Keep or drop this bit, then try the next lower one [RULE21]
               d.marker = q.marker >> 1;
               d.sar    = sar_decided | (q.marker >> 1);
            end
         end
         // Unused encoding returns to idle
         default: begin
            d.st = sarcc_pkg::SARCC_IDLE;
         end
      endcase

      // Read with select clears the done flag [RULE8]
      if (read_sel) begin
         d.done = 1'b0;
      end
      // Delay flop sets done a clock after the transfer; set beats the read clear [RULE15] [RULE7]
      if (q.done_delay_flop) begin
         d.done = 1'b1;
      end

      // A fall with select high also aborts: the code restarts from reset
      // Write-start falling edge clears code, stages and done [RULE3]
      if (wr_fall) begin
         d.st                = sarcc_pkg::SARCC_IDLE;
         d.sar               = sarcc_pkg::CODE_ZERO;
         d.marker            = sarcc_pkg::CODE_ZERO;
         d.done              = 1'b0;
         d.done_delay_flop   = 1'b0;
      end
      // Start condition sets the start flip-flop and aborts any run [RULE4] [RULE11]
      if (start_cond) begin
         d.st              = sarcc_pkg::SARCC_HOLD;
         d.first_shift_stage = (q.st == sarcc_pkg::SARCC_HOLD);
         d.sar             = sarcc_pkg::CODE_ZERO;
         d.marker          = sarcc_pkg::CODE_ZERO;
         d.done            = 1'b0;
         d.done_delay_flop = 1'b0;
      end
   end

   // Register the whole state
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '{st:                sarcc_pkg::SARCC_IDLE,
                first_shift_stage: 1'b0,
                marker:            sarcc_pkg::CODE_ZERO,
                sar:               sarcc_pkg::CODE_ZERO,
                phase:             '0,
                result:            sarcc_pkg::CODE_ZERO,
                done_delay_flop:   1'b0,
                done:              1'b0,
                wr_prev:           1'b1,
                conv_cyc:          sarcc_pkg::CYC_ZERO};
      end else begin
         q <= d;
      end
   end

   // Done pin is the inverted flag [RULE15]
   assign done_n = !q.done;
   // Latch drives the data pins only while selected for read [RULE9]
   assign data_out  = q.result;
   assign data_oe_n = !read_sel;
   // Trial code to the reference ladder
   assign trial_code = q.sar;
   // Input sample strobes, negative one four phases after positive [RULE18]
   assign sample_pos_p = (q.st == sarcc_pkg::SARCC_CONV) && (q.phase == sarcc_pkg::PH_POS);
   assign sample_neg_p = (q.st == sarcc_pkg::SARCC_CONV) && (q.phase == sarcc_pkg::PH_NEG);
   assign busy = (q.st != sarcc_pkg::SARCC_IDLE);

   // Checks on the sequencer
   localparam int GO_MAX = 7;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence released_s;
      (q.st == sarcc_pkg::SARCC_HOLD) && q.first_shift_stage && !start_cond;
   endsequence

   sequence go_s;
      ##[0:GO_MAX] (start_clear_gate || start_cond);
   endsequence

   // Positive sample followed by three cycles free of any abort
   sequence pos_quiet_s;
      (sample_pos_p && !start_cond && !wr_fall) ##1 (!start_cond && !wr_fall) [*3];
   endsequence

   hold_in_reset_a: assert property ( // [RULE4]
      start_cond |=> (q.st == sarcc_pkg::SARCC_HOLD) && (q.marker == sarcc_pkg::CODE_ZERO)
                     && done_n)
      else $error("start condition did not hold the converter reset");

   wr_fall_clears_a: assert property ( // [RULE3]
      wr_fall |=> done_n && (q.sar == sarcc_pkg::CODE_ZERO))
      else $error("write-start fall did not clear code and done");

   start_delay_a: assert property ( // [RULE5]
      released_s |-> go_s)
      else $error("conversion did not begin within eight periods");

   conv_length_a: assert property ( // [RULE1]
      latch_transfer_gate |-> (q.conv_cyc == sarcc_pkg::CYC_LAST))
      else $error("conversion length wrong");

   latch_load_a: assert property ( // [RULE14]
      latch_transfer_gate |=> (q.result == $past(sar_decided)) && q.done_delay_flop)
      else $error("output latch not loaded at transfer");

   done_set_a: assert property ( // [RULE15]
      q.done_delay_flop && !start_cond && !wr_fall |=> !done_n)
      else $error("done not set after delay flop");

   read_clear_a: assert property ( // [RULE8]
      read_sel && !q.done_delay_flop |=> done_n)
      else $error("read did not clear done");

   three_state_a: assert property ( // [RULE9]
      data_oe_n == !(!cs_s && !rd_s))
      else $error("data enable outside select and read");

   neg_sample_a: assert property ( // [RULE18]
      pos_quiet_s |=> sample_neg_p)
      else $error("negative sample not four phases after positive");

   abort_a: assert property ( // [RULE11]
      (q.st == sarcc_pkg::SARCC_CONV) && start_cond |=> (q.st == sarcc_pkg::SARCC_HOLD))
      else $error("new start did not abort conversion");

   // Bit sequencing: marker, first trial and each decision
   marker_onehot_a: assert property ( // [RULE6]
      (q.st == sarcc_pkg::SARCC_CONV) |-> $onehot(q.marker))
      else $error("shift register marker not one-hot while converting");

   trial_msb_a: assert property ( // [RULE5] [RULE6]
      start_clear_gate && !wr_fall |=> (q.st == sarcc_pkg::SARCC_CONV)
                                       && (q.sar == sarcc_pkg::MARK_MSB) && sample_pos_p)
      else $error("conversion did not open with the top trial bit");

   bit_keep_a: assert property ( // [RULE21]
      bit_end && !start_cond && !wr_fall
      |=> (((q.sar & $past(q.marker)) == sarcc_pkg::CODE_ZERO) == $past(cmp_s)))
      else $error("trial bit not decided by the comparator");

   // Output latch and done flag
   result_hold_a: assert property ( // [RULE14]
      !latch_transfer_gate |=> (q.result == $past(q.result)))
      else $error("output latch changed outside a transfer");

   done_fall_a: assert property ( // [RULE7] [RULE15]
      $fell(done_n) |-> $past(q.done_delay_flop))
      else $error("done fell without the delay flop");

   done_idle_a: assert property ( // [RULE7]
      !done_n |-> (q.st == sarcc_pkg::SARCC_IDLE))
      else $error("done shown while the sequencer is not idle");

   idle_marker_a: assert property ( // [RULE14]
      (q.st == sarcc_pkg::SARCC_IDLE) |-> (q.marker == sarcc_pkg::CODE_ZERO))
      else $error("marker left in the shift register while idle");

   neg_after_pos_a: assert property ( // [RULE18]
      sample_neg_p |-> $past(sample_pos_p, 4))
      else $error("negative sample without a positive one four cycles before");

endmodule

/* sarcc_pkg.sv */
/*
 * Shared constants and types of the successive-approximation conversion
 * control block: sequencing phases, code widths, pin indices, states.
 * Assumes one core clock, with one converter clock period per core cycle.
 */
package sarcc_pkg;

   // Result and trial code width
   localparam int unsigned RES_W = 8;

   // Phase counter of the internal converter clock: eight cycles per bit
   localparam int unsigned PH_W = 3;

   // Phase on which the start flip-flop may be cleared
   localparam logic [PH_W-1:0] PH_GO = 3'h7;

   // Phase late in a bit period, where the comparator is sampled; the
   // comparator reaches the core three cycles after a trial, so phase 5
   // is safe, and deciding here keeps a whole run inside its cycle budget
   localparam logic [PH_W-1:0] PH_CMP = 3'h5;

   // Phases of the positive and negative input sample strobes
   localparam logic [PH_W-1:0] PH_POS = 3'h0;
   localparam logic [PH_W-1:0] PH_NEG = 3'h4;

   // Marker positions in the shift register and the cleared code
   localparam logic [RES_W-1:0] MARK_MSB = 8'h80;
   localparam logic [RES_W-1:0] MARK_LSB = 8'h01;
   localparam logic [RES_W-1:0] CODE_ZERO = 8'h00;

   // Cycle counter of a running conversion and its value at transfer
   localparam int unsigned CYC_W = 7;
   localparam logic [CYC_W-1:0] CYC_ZERO = 7'h00;
   localparam logic [CYC_W-1:0] CYC_ONE = 7'h01;
   localparam logic [CYC_W-1:0] CYC_LAST = 7'h3d;

   // Bit positions of the synchronised pins
   localparam int unsigned PIN_W = 4;
   localparam int unsigned IX_CS = 0;
   localparam int unsigned IX_WR = 1;
   localparam int unsigned IX_RD = 2;
   localparam int unsigned IX_CMP = 3;

   // Synchroniser reset value: strobes inactive high, comparator low
   localparam logic [PIN_W-1:0] PIN_RST = 4'h7;

   // Sequencer states
   typedef enum logic [1:0] {
      SARCC_IDLE,
      SARCC_HOLD,
      SARCC_CONV
   } sarcc_state_e;

endpackage

/* sarcc_pin_if.sv */
/*
 * Carrier between the pin synchroniser and the sequencer core.
 * Assumes raw pins are asynchronous and the synchronised copy is core_clk.
 */
`timescale 1ns/1ns
interface sarcc_pin_if;
   logic [sarcc_pkg::PIN_W-1:0] raw;   // Pins as they arrive
   logic [sarcc_pkg::PIN_W-1:0] sync;  // Pins after two flip-flops

   // Synchroniser side
   modport sync_side (input raw, output sync);
   // Sequencer side
   modport core_side (output raw, input sync);
endinterface

/* sarcc_sync.sv */
/*
 * Two-flip-flop synchroniser for the control pins and comparator input.
 * Assumes core_clk and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
module sarcc_sync (
   input wire logic      core_clk,
   input wire logic      resetn,
   sarcc_pin_if.sync_side pins
);

   // Both stages of the chain
   typedef struct packed {
      logic [sarcc_pkg::PIN_W-1:0] s1;
      logic [sarcc_pkg::PIN_W-1:0] s2;
   } sarcc_sync_s;

   sarcc_sync_s q;
   sarcc_sync_s d;

   // Next value: first stage reads pins, second reads only the first
   always_comb begin
      d    = q;
      d.s1 = pins.raw;
      d.s2 = q.s1;
   end

   // Register the chain
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '{s1: sarcc_pkg::PIN_RST, s2: sarcc_pkg::PIN_RST};
      end else begin
         q <= d;
      end
   end

   // Only the second stage leaves the module
   assign pins.sync = q.s2;

endmodule

/* sarcc_cmp_model.sv */
/*
 * Stand-in for the analogue comparator: compares the trial code with an
 * ideal input code and reports whether the trial lies above it.
 * Assumes trial_code holds for several core_clk cycles per bit.
 */
`timescale 1ns/1ns
module sarcc_cmp_model (
   input  wire logic                         core_clk,
   input  wire logic [sarcc_pkg::RES_W-1:0]  trial_code,
   input  wire logic [sarcc_pkg::RES_W-1:0]  vin,
   output logic                              cmp_hi
);
   // Known level before the first clock
   initial cmp_hi = 1'b0;

   // High drops the trial bit, so the result settles on vin
   always @(posedge core_clk) begin
      cmp_hi <= (trial_code > vin);
   end
endmodule

/* sarcc_tb.sv */
/*
 * Self-checking bench of the conversion control: row loop of conversions,
 * then held start, abort, write-start fall, mid-run reset and free running.
 * Assumes sarcc_core is the design under test and sarcc_cmp_model stands in for the comparator.
 */
`timescale 1ns/1ns
module sarcc_tb;
   typedef struct { logic [7:0] vin; logic [7:0] code; } sarcc_row_s;
   logic       core_clk, resetn, cs_n, wr_n, rd_n, cmp_hi, free_run;
   logic       done_n, data_oe_n, sample_pos_p, sample_neg_p, busy;
   logic [7:0] vin, data_out, trial_code;
   logic       done_q = 1'b1;  // done_n one cycle earlier
   int         n_fail, comparisons, cyc, last_pos, n_pos, n_done, n, first_pos, p;
   // Input code beside the result it must give
   sarcc_row_s rows [7] = '{'{8'h00, 8'h00}, '{8'hff, 8'hff}, '{8'h80, 8'h80},
                            '{8'h7f, 8'h7f}, '{8'h55, 8'h55}, '{8'haa, 8'haa},
                            '{8'h01, 8'h01}};

   sarcc_core dut (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .wr_n(wr_n),
      .rd_n(rd_n), .cmp_hi(cmp_hi), .done_n(done_n), .data_out(data_out),
      .data_oe_n(data_oe_n), .trial_code(trial_code), .sample_pos_p(sample_pos_p),
      .sample_neg_p(sample_neg_p), .busy(busy));
   sarcc_cmp_model cmp (.core_clk(core_clk), .trial_code(trial_code), .vin(vin),
      .cmp_hi(cmp_hi));

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Free running: done fed back to write-start
   always @(posedge core_clk) begin
      if (free_run) wr_n <= done_n;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Watches sample strobes and done, after the edge has settled; cuts hangs
   always @(posedge core_clk) begin
      #2;
      cyc++;
      if (sample_pos_p === 1'b1) begin
         last_pos = cyc;
         n_pos++;
      end
      if (sample_neg_p === 1'b1) check(16'(cyc - last_pos), 16'h4, "neg spacing");
      if (done_q === 1'b1 && done_n === 1'b0) n_done++;
      done_q = done_n;
      if (cyc == 6000) begin
         n_fail++;
         close_out();
      end
   end

   // Reset state of the outputs
   task automatic chk_idle();
      @(negedge core_clk);
      check(16'({done_n, data_oe_n, busy}), 16'h6, "idle flags");
      check(16'({trial_code, data_out}), 16'h0, "idle codes");
   endtask

   // Start condition held for some cycles, then released at an edge
   task automatic start_pulse(input int hold);
      @(posedge core_clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      repeat (hold) @(posedge core_clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
   endtask

   // Select and read strobe low, result out, then released
   task automatic read_out(input logic [7:0] code);
      @(posedge core_clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check(16'(data_oe_n), 16'h0, "read enable");
      check(16'(data_out), 16'(code), "result");
      check(16'(done_n), 16'h1, "read clears done");
      @(posedge core_clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check(16'(data_oe_n), 16'h1, "read release");
   endtask

   // Counts edges from release to done, then reads the result
   task automatic run_conv(input logic [7:0] code);
      p = n_pos;
      n = 0;
      first_pos = 0;
      while (done_n !== 1'b0 && n < 200) begin
         @(posedge core_clk);
         @(negedge core_clk);
         n++;
         if (first_pos == 0 && n_pos != p) first_pos = n;
      end
      check(16'(n >= 62 && n <= 73), 16'h1, "conversion length");
      check(16'(first_pos >= 3 && first_pos <= 10), 16'h1, "start delay");
      check(16'(n_pos - p), 16'h8, "bit periods");
      check(16'({busy, data_oe_n}), 16'h1, "idle at done");
      read_out(code);
   endtask

   initial begin
      resetn = 1'b0;
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      vin = 8'h00;
      free_run = 1'b0;
      repeat (12) @(posedge core_clk);
      chk_idle();
      $display("test reset done");
      @(posedge core_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge core_clk);
      foreach (rows[i]) begin
         @(posedge core_clk);
         vin <= rows[i].vin;
         start_pulse(3);
         run_conv(rows[i].code);
         $display("test row %0d done", i);
      end
      // Wide start: held in reset, then write-start rise starts it
      @(posedge core_clk);
      vin <= 8'h3c;
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      p = n_pos;
      repeat (100) @(posedge core_clk);
      @(negedge core_clk);
      check(16'({busy, done_n}), 16'h3, "held start");
      check(16'(n_pos - p), 16'h0, "no bits while held");
      @(posedge core_clk);
      wr_n <= 1'b1;
      run_conv(8'h3c);
      $display("test held start done");
      // Second start in mid conversion restarts with the new input
      @(posedge core_clk);
      vin <= 8'h11;
      start_pulse(3);
      repeat (30) @(posedge core_clk);
      vin <= 8'hc3;
      start_pulse(3);
      run_conv(8'hc3);
      $display("test abort done");
      // Write-start fall alone clears a pending done
      start_pulse(3);
      repeat (80) @(posedge core_clk);
      @(negedge core_clk);
      check(16'(done_n), 16'h0, "done pending");
      @(posedge core_clk);
      wr_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      check(16'(done_n), 16'h1, "fall clears done");
      @(posedge core_clk);
      wr_n <= 1'b1;
      repeat (100) @(posedge core_clk);
      $display("test write fall done");
      // Reset in mid conversion
      start_pulse(3);
      repeat (20) @(posedge core_clk);
      resetn <= 1'b0;
      chk_idle();
      @(posedge core_clk);
      resetn <= 1'b1;
      $display("test mid reset done");
      // Select tied low, explicit first start, then free running
      @(posedge core_clk);
      vin <= 8'h96;
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      wr_n <= 1'b1;
      free_run <= 1'b1;
      p = n_done;
      repeat (800) @(posedge core_clk);
      check(16'(n_done - p >= 9 && n_done - p <= 13), 16'h1, "free-run rate");
      free_run <= 1'b0;
      @(posedge core_clk);
      wr_n <= 1'b1;
      cs_n <= 1'b1;
      $display("test free run done");
      close_out();
   end
endmodule
